// ### src/tas_pkg.sv
// Package for the time-slot access, loop and switch block.
// Assumes one 200 MHz system clock; the frame bus arrives asynchronously.
// Functional notes
// - Swap set: each register takes input slot and line from its partner's config.
// - Looping captures the slot on the line opposite its output (upstream when line select is 1) and drives it back one frame later.
// - Shift with target at least source plus two completes within the same frame.
// - Target right after or before source goes out in the following frame.
// - Loop and shift run every frame alone; host works between transfer and overflow.
// - Arbitration monitor enable makes the even register capture arbitration slot 11.
// - Arbitration monitor still lets odd register watch slot 3 on either line.
// - Four transfer and four overflow events, one of each per register, in status.
// - Transfer event two bit clocks after slot, or one when line select is 1.
// - One bit clock counts as two periods of the double-rate clock.
// - Overflow follows its own unmasked transfer event when left unacknowledged.
// - If own transfer event is masked, overflow follows any other unacknowledged one.
// - With every transfer event masked, no transfer or overflow event occurs.
// - Transfer event needs the register input enabled; output alone never causes it.
// - Overflow event needs the register output enabled; input alone never causes it.
// - No overflow when every stimulating transfer event was acknowledged in time.
// - Config selects slot 0 to 31 and places the output upstream or downstream.
// - Input disabled: register keeps its value and keeps driving it.

package tas_pkg;

   // Register byte addresses on the bus.
   localparam logic [7:0] ADR_DATA0 = 8'h00;
   localparam logic [7:0] ADR_CFG0 = 8'h10;
   localparam logic [7:0] ADR_CTRL0 = 8'h20;
   localparam logic [7:0] ADR_CTRL1 = 8'h24;
   localparam logic [7:0] ADR_MASK = 8'h28;
   localparam logic [7:0] ADR_ACK = 8'h2c;
   localparam logic [7:0] ADR_STAT = 8'h30;

   // Values after reset.
   localparam logic [7:0] RST_DATA = 8'hff;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_MASK = 8'hff;

   // Field positions.
   localparam int CFG_LS_BIT = 7;
   localparam int CTRL_IN_EN = 0;
   localparam int CTRL_OUT_EN = 2;
   localparam int CTRL_SWAP = 4;
   localparam int CTRL_ARB = 5;

   // Frame timing.
   localparam logic [4:0] ARB_SLOT = 5'h0b;
   localparam logic [7:0] SLOT_BITS = 8'h08;
   localparam logic [7:0] STI_DLY_LS0 = 8'h02;
   localparam logic [7:0] STI_DLY_LS1 = 8'h01;
   localparam int BIT_DCL = 2;

   typedef struct packed {
      logic bit_start;
      logic sample;
      logic [7:0] bit_idx;
      logic du;
      logic dd;
   } tas_tick_t;

   typedef enum logic [1:0] {
      TAS_HUNT = 2'b00,
      TAS_RUN = 2'b01
   } tas_sync_st_t;

   function automatic logic [7:0] tas_slot_bit(input logic [4:0] slot);
      return {slot, 3'b000};
   endfunction

   function automatic logic [7:0] tas_dly(input logic ls);
      return ls ? STI_DLY_LS1 : STI_DLY_LS0;
   endfunction

endpackage

// ### src/tas_link_timer.sv
// Frame timer: synchronises the frame bus pins and derives bit ticks.
// Assumes the double-rate clock is far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none

module tas_link_timer
   import tas_pkg::*;
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Frame bus pins
   input wire logic fsc_i,
   input wire logic dcl_i,
   input wire logic du_i,
   input wire logic dd_i,
   // Ticks
   output tas_tick_t tick_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [1:0] fsc_s_ff;
   logic [1:0] dcl_s_ff;
   logic [1:0] du_s_ff;
   logic [1:0] dd_s_ff;
   logic fsc_d_ff;
   logic dcl_d_ff;
   logic fsc_pend_ff;
   logic [8:0] half_ff;
   tas_sync_st_t st_ff;
   tas_tick_t tick_ff;
   logic dcl_rise;
   logic dcl_fall;
   logic [8:0] nxt_half;

   always_ff @(posedge clk_i)
   begin
      fsc_s_ff <= {fsc_s_ff[0], fsc_i};
      dcl_s_ff <= {dcl_s_ff[0], dcl_i};
      du_s_ff <= {du_s_ff[0], du_i};
      dd_s_ff <= {dd_s_ff[0], dd_i};
      fsc_d_ff <= fsc_s_ff[1];
      dcl_d_ff <= dcl_s_ff[1];
   end

   assign dcl_rise = dcl_s_ff[1] & ~dcl_d_ff;
   assign dcl_fall = ~dcl_s_ff[1] & dcl_d_ff;
   assign nxt_half = fsc_pend_ff ? 9'h000 : half_ff + 9'h001;

   ////////////////////////////////////////////////////////////////////////
   // A frame pulse re-aligns the count at the next double-rate rising edge.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         fsc_pend_ff <= 1'b0;
         half_ff <= 9'h000;
         st_ff <= TAS_HUNT;
      end
      else
      begin
         if (fsc_s_ff[1] & ~fsc_d_ff)
            fsc_pend_ff <= 1'b1;
         else if (dcl_rise)
            fsc_pend_ff <= 1'b0;
         if (dcl_rise)
         begin
            half_ff <= nxt_half;
            case (st_ff)
               TAS_HUNT:
                  if (fsc_pend_ff)
                     st_ff <= TAS_RUN;
               default:
                  st_ff <= TAS_RUN;
            endcase
         end
      end
   end

   // Two double-rate periods make one bit: drive on the first rising
   // edge, sample on the falling edge of the second period.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tick_ff <= '0;
      else
      begin
         tick_ff.bit_start <= dcl_rise & ~nxt_half[0] & (st_ff == TAS_RUN | fsc_pend_ff);
         tick_ff.sample <= dcl_fall & half_ff[0] & (st_ff == TAS_RUN);
         if (dcl_rise)
            tick_ff.bit_idx <= nxt_half[8:1];
         if (dcl_fall & half_ff[0])
         begin
            tick_ff.du <= du_s_ff[1];
            tick_ff.dd <= dd_s_ff[1];
         end
      end
   end

   assign tick_o = tick_ff;

endmodule

`default_nettype wire

// ### src/tas_irq_unit.sv
// Transfer and overflow event logic for the four slot access registers.
// Assumes one-cycle event pulses from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module tas_irq_unit (
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Events
   input wire logic [3:0] sti_evt_i,
   input wire logic [3:0] dead_evt_i,
   // Software
   input wire logic [3:0] ack_i,
   input wire logic [7:0] clr_i,
   input wire logic [7:0] mask_i,
   input wire logic [3:0] in_en_i,
   input wire logic [3:0] out_en_i,
   // State
   output logic [7:0] status_o,
   output logic [3:0] pend_o
);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] status_ff;
   logic [3:0] pend_ff;
   logic [3:0] sti_unm;
   logic [3:0] overflow_irq_unm;
   logic [3:0] sti_set;
   logic [3:0] miss;
   logic [3:0] overflow_irq_set;

   assign sti_unm = ~mask_i[3:0];
   assign overflow_irq_unm = ~mask_i[7:4];
   assign sti_set = sti_evt_i & in_en_i & sti_unm;
   // A transfer event masked after it was raised can no longer cause an overflow.
   assign miss = dead_evt_i & pend_ff & sti_unm;

   always_comb
   begin
      for (int j = 0; j < 4; j++)
      begin
         if (sti_unm[j])
            overflow_irq_set[j] = miss[j];
         else
            overflow_irq_set[j] = |(miss & ~(4'h1 << j));
         overflow_irq_set[j] = overflow_irq_set[j] & overflow_irq_unm[j] & out_en_i[j];
      end
   end

   // An acknowledge that meets a new transfer event loses to it.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pend_ff <= 4'h0;
      else
         pend_ff <= (pend_ff & ~ack_i & ~dead_evt_i) | sti_set;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         status_ff <= 8'h00;
      else
         status_ff <= (status_ff & ~clr_i) | {overflow_irq_set, sti_set};
   end

   assign status_o = status_ff;
   assign pend_o = pend_ff;

endmodule

`default_nettype wire

// ### src/tas_top.sv
// Slot access unit: four byte registers that loop, shift, switch or
// monitor time slots of the serial frame bus, reached over Wishbone.
// Assumes a classic Wishbone master and a 32-slot frame of 8-bit slots.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tas_top
   import tas_pkg::*;
#(
   parameter int ADR_W = 8
)
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Frame bus
   input wire logic fsc_i,
   input wire logic dcl_i,
   input wire logic du_i,
   input wire logic dd_i,
   output logic du_o,
   output logic du_oe_o,
   output logic dd_o,
   output logic dd_oe_o
);

   if (ADR_W < 6)
      $error("ADR_W must be at least 6");

   ////////////////////////////////////////////////////////////////////////
   tas_tick_t tick;
   logic [7:0] data_ff [4];
   logic [7:0] cfg_ff [4];
   logic [7:0] obyte_ff [4];
   logic [7:0] ctrl_ff [2];
   logic [7:0] mask_ff;
   logic [7:0] du_sh_ff;
   logic [7:0] dd_sh_ff;
   logic [7:0] rx_du_ff;
   logic [7:0] rx_dd_ff;
   logic [4:0] rx_slot_ff;
   logic rx_pend_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic du_o_ff;
   logic du_oe_ff;
   logic dd_o_ff;
   logic dd_oe_ff;
   logic [7:0] status;
   logic [3:0] pend;
   logic [7:0] adr;
   logic wr_go;
   logic [3:0] ack_wr;
   logic [7:0] stat_clr;
   logic [4:0] in_slot [4];
   logic in_from_du [4];
   logic [3:0] in_en;
   logic [3:0] out_en;
   logic [3:0] hit_out;
   logic [7:0] cur [4];
   logic [3:0] sti_evt;
   logic [3:0] dead_evt;
   logic [2:0] bit_pos;
   logic [4:0] slot;

   assign adr = 8'(wb_adr_i);
   assign bit_pos = tick.bit_idx[2:0];
   assign slot = tick.bit_idx[7:3];

   tas_link_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .fsc_i(fsc_i),
      .dcl_i(dcl_i),
      .du_i(du_i),
      .dd_i(dd_i),
      .tick_o(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Input and output routing per register.
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         logic [7:0] src;
         src = cfg_ff[i];
         if (ctrl_ff[i/2][CTRL_SWAP])
            src = cfg_ff[i^1];
         in_slot[i] = src[4:0];
         // Line select 1 puts the output downstream, so input comes upstream.
         in_from_du[i] = src[CFG_LS_BIT];
         if (ctrl_ff[i/2][CTRL_ARB] && (i % 2 == 0))
         begin
            in_slot[i] = ARB_SLOT;
            in_from_du[i] = ~cfg_ff[i][CFG_LS_BIT];
         end
         in_en[i] = ctrl_ff[i/2][CTRL_IN_EN + i%2];
         out_en[i] = ctrl_ff[i/2][CTRL_OUT_EN + i%2];
         hit_out[i] = out_en[i] && (cfg_ff[i][4:0] == slot);
         cur[i] = (bit_pos == 3'h0) ? data_ff[i] : obyte_ff[i];
         sti_evt[i] = tick.bit_start && (tick.bit_idx == tas_slot_bit(cfg_ff[i][4:0])
            + SLOT_BITS + tas_dly(cfg_ff[i][CFG_LS_BIT]));
         dead_evt[i] = tick.bit_start && (tick.bit_idx == tas_slot_bit(cfg_ff[i][4:0])
            - tas_dly(cfg_ff[i][CFG_LS_BIT]));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive shift registers; a slot's bytes are complete at its last sample.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         du_sh_ff <= 8'hff;
         dd_sh_ff <= 8'hff;
         rx_du_ff <= 8'hff;
         rx_dd_ff <= 8'hff;
         rx_slot_ff <= 5'h00;
         rx_pend_ff <= 1'b0;
      end
      else
      begin
         if (tick.sample)
         begin
            du_sh_ff <= {du_sh_ff[6:0], tick.du};
            dd_sh_ff <= {dd_sh_ff[6:0], tick.dd};
         end
         if (tick.sample && bit_pos == 3'h7)
         begin
            rx_du_ff <= {du_sh_ff[6:0], tick.du};
            rx_dd_ff <= {dd_sh_ff[6:0], tick.dd};
            rx_slot_ff <= slot;
            rx_pend_ff <= 1'b1;
         end
         else if (tick.bit_start)
            rx_pend_ff <= 1'b0;
      end
   end

   // A captured byte is committed at the first bit of the next slot, the
   // same edge at which output bytes are latched. A target slot right
   // after the source therefore still sends last frame's byte.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 4; i++)
            data_ff[i] <= RST_DATA;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (tick.bit_start && rx_pend_ff && in_en[i] && in_slot[i] == rx_slot_ff)
               data_ff[i] <= in_from_du[i] ? rx_du_ff : rx_dd_ff;
            if (wr_go && wb_sel_i[0] && adr == ADR_DATA0 + 8'(4 * i))
               data_ff[i] <= wb_dat_i[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit: each bit start in an output slot shifts out the byte MSB
   // first. Overlapping drivers on a line combine as wired-and.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 4; i++)
            obyte_ff[i] <= RST_DATA;
         du_o_ff <= 1'b1;
         du_oe_ff <= 1'b0;
         dd_o_ff <= 1'b1;
         dd_oe_ff <= 1'b0;
      end
      else if (tick.bit_start)
      begin
         logic nu;
         logic nd;
         logic eu;
         logic ed;
         nu = 1'b1;
         nd = 1'b1;
         eu = 1'b0;
         ed = 1'b0;
         for (int i = 0; i < 4; i++)
         begin
            if (hit_out[i])
            begin
               obyte_ff[i] <= {cur[i][6:0], 1'b1};
               if (cfg_ff[i][CFG_LS_BIT])
               begin
                  nd = nd & cur[i][7];
                  ed = 1'b1;
               end
               else
               begin
                  nu = nu & cur[i][7];
                  eu = 1'b1;
               end
            end
         end
         du_o_ff <= nu;
         du_oe_ff <= eu;
         dd_o_ff <= nd;
         dd_oe_ff <= ed;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wishbone: ack one cycle after the request; writes land on the ack edge.
   assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_ff <= 1'b0;
      else
         ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
   end

   always_comb
   begin
      ack_wr = 4'h0;
      stat_clr = 8'h00;
      if (wr_go && wb_sel_i[0] && adr == ADR_ACK)
         ack_wr = wb_dat_i[3:0];
      if (wr_go && wb_sel_i[0] && adr == ADR_STAT)
         stat_clr = wb_dat_i[7:0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < 4; i++)
            cfg_ff[i] <= RST_CFG;
         ctrl_ff[0] <= RST_CTRL;
         ctrl_ff[1] <= RST_CTRL;
         mask_ff <= RST_MASK;
      end
      else if (wr_go && wb_sel_i[0])
      begin
         if (adr == ADR_CTRL0)
            ctrl_ff[0] <= {2'b00, wb_dat_i[5:0]};
         else if (adr == ADR_CTRL1)
            ctrl_ff[1] <= {2'b00, wb_dat_i[5:0]};
         else if (adr == ADR_MASK)
            mask_ff <= wb_dat_i[7:0];
         else
         begin
            for (int i = 0; i < 4; i++)
               if (adr == ADR_CFG0 + 8'(4 * i))
                  cfg_ff[i] <= {wb_dat_i[7], 2'b00, wb_dat_i[4:0]};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdat_ff <= 32'h0000_0000;
      else if (wb_cyc_i && wb_stb_i && !ack_ff)
      begin
         rdat_ff <= 32'h0000_0000;
         if (adr == ADR_CTRL0)
            rdat_ff[7:0] <= ctrl_ff[0];
         else if (adr == ADR_CTRL1)
            rdat_ff[7:0] <= ctrl_ff[1];
         else if (adr == ADR_MASK)
            rdat_ff[7:0] <= mask_ff;
         else if (adr == ADR_ACK)
            rdat_ff[3:0] <= pend;
         else if (adr == ADR_STAT)
            rdat_ff[7:0] <= status;
         else
         begin
            for (int i = 0; i < 4; i++)
            begin
               if (adr == ADR_DATA0 + 8'(4 * i))
                  rdat_ff[7:0] <= data_ff[i];
               if (adr == ADR_CFG0 + 8'(4 * i))
                  rdat_ff[7:0] <= cfg_ff[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   tas_irq_unit u_irq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .sti_evt_i(sti_evt),
      .dead_evt_i(dead_evt),
      .ack_i(ack_wr),
      .clr_i(stat_clr),
      .mask_i(mask_ff),
      .in_en_i(in_en),
      .out_en_i(out_en),
      .status_o(status),
      .pend_o(pend)
   );

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign du_o = du_o_ff;
   assign du_oe_o = du_oe_ff;
   assign dd_o = dd_o_ff;
   assign dd_oe_o = dd_oe_ff;

endmodule

`default_nettype wire

// ### tb/tas_props.sv
// Checker for the slot access unit: bus handshake and frame bus drive timing.
// Assumes a 160 ns double-rate clock, so one bit spans 64 system clocks.
`timescale 1ns/1ps
`default_nettype none

module tas_props #(
   parameter int ADR_W = 8
)
(
   // System
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Frame bus
   input wire logic dcl_i,
   input wire logic du_o,
   input wire logic du_oe_o,
   input wire logic dd_o,
   input wire logic dd_oe_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   ////////////////////////////////////////
   logic dd_prev_ff;
   logic [9:0] hold_ff;
   logic [9:0] oe_len_ff;

   always_ff @(posedge clk_i)
   begin
      dd_prev_ff <= dd_o;
      if (rst_i || !dd_oe_o || dd_o != dd_prev_ff)
         hold_ff <= 10'h000;
      else if (hold_ff != 10'h3ff)
         hold_ff <= hold_ff + 10'h001;
   end

   // Only a lower bound: adjacent output slots legally merge into one drive.
   always_ff @(posedge clk_i)
      if (rst_i || !du_oe_o)
         oe_len_ff <= 10'h000;
      else if (oe_len_ff != 10'h3ff)
         oe_len_ff <= oe_len_ff + 10'h001;

   ////////////////////////////////////////
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   ack_pulse_a: assert property (s_req |=> s_ack_pulse)
      else $error("request not answered by a one-cycle ack");
   ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without a request");
   upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:0] > 8'h30
      |-> wb_dat_o == 32'h00000000) else $error("unmapped read not zero");
   reset_quiet_a: assert property (disable iff (1'b0)
      rst_i |=> !wb_ack_o && !du_oe_o && !dd_oe_o && du_o && dd_o)
      else $error("outputs active after reset");
   idle_high_a: assert property (!du_oe_o && !dd_oe_o |-> du_o && dd_o)
      else $error("released line not idle high");
   bit_hold_a: assert property (
      dd_oe_o && $past(dd_oe_o) && $changed(dd_o) |-> hold_ff >= 10'h038)
      else $error("driven bit shorter than two double-rate periods");
   slot_len_a: assert property ($fell(du_oe_o) |-> oe_len_ff >= 10'h1f4)
      else $error("output slot shorter than eight bits");
   drive_start_a: assert property ($rose(dd_oe_o) |-> dcl_i && !$past(dcl_i, 8))
      else $error("drive not started at a double-rate clock rise");
endmodule

bind tas_top tas_props #(.ADR_W(ADR_W)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .dcl_i(dcl_i), .du_o(du_o), .du_oe_o(du_oe_o), .dd_o(dd_o), .dd_oe_o(dd_oe_o)
);
`default_nettype wire

// ### tb/tas_link_model.sv
// Far side of the frame bus: frame sync, free-running double-rate clock, lines.
// Upstream even slots carry a frame-stamped byte; other slots and the
// downstream line are released to their pull-ups. Every line bit is recorded.
`timescale 1ns/1ps
`default_nettype none

module tas_link_model (
   // Block drive
   input wire logic du_drv_i,
   input wire logic du_oe_i,
   input wire logic dd_drv_i,
   input wire logic dd_oe_i,
   // Lines
   output logic fsc_o,
   output logic dcl_o,
   output logic du_o,
   output logic dd_o
);
   int frm;
   logic far_du;
   logic [7:0] du_h [8][32];
   logic [7:0] dd_h [8][32];

   // Open-drain lines: whoever pulls low wins.
   assign du_o = far_du & (du_oe_i ? du_drv_i : 1'b1);
   assign dd_o = dd_oe_i ? dd_drv_i : 1'b1;

   initial
   begin
      logic [7:0] pat;
      frm = 0;
      fsc_o = 1'b0;
      dcl_o = 1'b0;
      far_du = 1'b1;
      #1001;
      fsc_o = 1'b1;
      #40;
      forever
      begin
         for (int b = 0; b < 256; b++)
            for (int h = 0; h < 2; h++)
            begin
               pat = {frm[2:0], b[7:3]} ^ 8'ha5;
               dcl_o = 1'b1;
               if (h == 0)
                  far_du = b[3] | pat[7 - b[2:0]];
               #80;
               dcl_o = 1'b0;
               if (h == 1)
               begin
                  du_h[frm % 8][b / 8][7 - b % 8] = du_o;
                  dd_h[frm % 8][b / 8][7 - b % 8] = dd_o;
               end
               #40;
               fsc_o = (b == 255 && h == 1);
               #40;
            end
         frm++;
      end
   end
endmodule
`default_nettype wire

// ### tb/tas_top_tb_top.sv
// Bench for the slot access unit: registers, looping, shifting, holding and
// the transfer and overflow status events. Assumes the link model's records.
`timescale 1ns/1ps
`default_nettype none

module tas_top_tb_top
   import tas_pkg::*;
;
   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [7:0] wb_adr;
   logic [31:0] wb_wdat, wb_rdat;
   logic fsc, double_rate_clock, du_line, dd_line, du_drv, du_oe, dd_drv, dd_oe;
   int err_total, checks_done;

   tas_top dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .fsc_i(fsc), .dcl_i(double_rate_clock), .du_i(du_line), .dd_i(dd_line),
      .du_o(du_drv), .du_oe_o(du_oe), .dd_o(dd_drv), .dd_oe_o(dd_oe)
   );
   tas_link_model lnk (
      .du_drv_i(du_drv), .du_oe_i(du_oe), .dd_drv_i(dd_drv), .dd_oe_i(dd_oe),
      .fsc_o(fsc), .dcl_o(double_rate_clock), .du_o(du_line), .dd_o(dd_line)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic give_up(input logic hung);
      if (hung)
      begin
         err_total++;
         tally_and_finish();
      end
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // The slave's ack paces each cycle; the bound only cuts a hang short.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_wdat <= {24'h000000, d};
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 64);
      q = wb_rdat[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      give_up(wb_ack !== 1'b1);
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(what, q, exp);
   endtask

   task automatic wait_frm(input int f);
      int n;
      n = 0;
      while (lnk.frm < f && n < 40000)
      begin
         @(posedge clk_i);
         n++;
      end
      give_up(n >= 40000);
   endtask

   // Polls status until the first register's transfer event shows.
   task automatic wait_t0();
      logic [7:0] q;
      int n;
      q = 8'h00;
      n = 0;
      while (q[0] !== 1'b1 && n < 9000)
      begin
         bus(1'b0, ADR_STAT, 8'h00, q);
         n++;
      end
      give_up(n >= 9000);
   endtask

   ////////////////////////////////////////
   initial
   begin
      err_total = 0;
      checks_done = 0;
      rst_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_wdat = 32'h00000000;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("data0", ADR_DATA0, RST_DATA);
      rdc("cfg0", ADR_CFG0, RST_CFG);
      rdc("ctrl1", ADR_CTRL1, RST_CTRL);
      rdc("mask", ADR_MASK, RST_MASK);
      rdc("unmapped", 8'h3c, 8'h00);
      wr(ADR_CFG0, 8'he4);
      rdc("cfg0 back", ADR_CFG0, 8'h84);
      wr(ADR_CFG0 + 8'h04, 8'h86);
      wr(ADR_DATA0 + 8'h04, 8'h5a);
      wr(ADR_CFG0 + 8'h08, 8'h82);
      wr(ADR_CFG0 + 8'h0c, 8'h07);
      wr(ADR_CTRL0, 8'h0d);
      wr(ADR_CTRL1, 8'h1a);
      wr(ADR_MASK, 8'hca);
      wait_frm(2);
      rdc("status", ADR_STAT, 8'h31);
      chk("loop", lnk.dd_h[1][4], lnk.du_h[0][4]);
      chk("shift", lnk.du_h[1][7], lnk.du_h[1][2]);
      chk("held", lnk.dd_h[1][6], 8'h5a);
      wr(ADR_CFG0 + 8'h0c, 8'h01);
      wr(ADR_STAT, 8'hff);
      wait_t0();
      wr(ADR_ACK, 8'h01);
      wr(ADR_STAT, 8'hff);
      wait_t0();
      rdc("acked", ADR_STAT, 8'h01);
      wr(ADR_ACK, 8'h01);
      wr(ADR_MASK, 8'h0f);
      wr(ADR_STAT, 8'hff);
      wait_frm(5);
      rdc("all masked", ADR_STAT, 8'h00);
      chk("wrap shift", lnk.du_h[3][1], lnk.du_h[2][2]);
      chk("loop again", lnk.dd_h[4][4], lnk.du_h[3][4]);
      // Register 3 now drives the arbitration slot, so the monitor sees a frame byte.
      wr(ADR_CFG0 + 8'h0c, 8'h0b);
      wr(ADR_CFG0, 8'h08);
      wr(ADR_CFG0 + 8'h04, 8'h83);
      wr(ADR_CTRL0, 8'h23);
      repeat (7000) @(posedge clk_i);
      rdc("arb monitor", ADR_DATA0, lnk.du_h[5][11]);
      rdc("slot3 monitor", ADR_DATA0 + 8'h04, lnk.du_h[5][3]);
      tally_and_finish();
   end
endmodule
`default_nettype wire
